// file: src/amp_fault_pkg.sv
package amp_fault_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] OLCNT_OFFSET  = 8'h08;

    // control register fields
    localparam int TRIP_LSB = 0;
    localparam int TRIP_W   = 4;
    localparam int CFG_LSB  = 4;
    localparam int CFG_W    = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status register fields
    localparam int ST_ALERT_BIT   = 0;
    localparam int ST_WARN_BIT    = 1;
    localparam int ST_THERMAL_BIT = 2;
    localparam int ST_SUPPLY_BIT  = 3;
    localparam int ST_OVL_LSB     = 4;
    localparam int ST_FLIP_LSB    = 8;
    localparam int ST_BST_LSB     = 12;
    localparam int ST_MODE_BIT    = 16;
    localparam int ST_LEVEL_LSB   = 18;

    localparam int HB_COUNT = 4;
    localparam int OLCNT_FIELD_W = 8;

    // current trip setting codes: 0..3 per-cycle, 4..7 latched, rest invalid
    localparam logic [3:0] TRIP_PC_FIRST  = 4'h0;
    localparam logic [3:0] TRIP_PC_LAST   = 4'h3;
    localparam logic [3:0] TRIP_LAT_FIRST = 4'h4;
    localparam logic [3:0] TRIP_LAT_LAST  = 4'h7;
    // threshold level codes, 17.0A / 15.7A / 14.2A / 12.9A
    localparam logic [1:0] LEVEL_17A0 = 2'h0;
    localparam logic [1:0] LEVEL_12A9 = 2'h3;

    // output configurations
    typedef enum logic [1:0] {
        CFG_BTL  = 2'h0,
        CFG_PBTL = 2'h1,
        CFG_SE   = 2'h2
    } out_cfg_type;

    // sensed analog conditions, asynchronous to mclk
    typedef struct packed {
        logic [3:0] over_current;
        logic [3:0] bootstrap_supply_low;
        logic       temp_warn;
        logic       temp_shutdown;
        logic       supply_low;
    } sense_type;

    // drive to the four half-bridges
    typedef struct packed {
        logic [3:0] hiz;
        logic [3:0] flip;
        logic [3:0] high_side_off;
    } bridge_ctrl_type;

endpackage : amp_fault_pkg

// file: src/amplifier_fault_protection.sv
// Function
// (R1) both report outputs are active-low open-drain pins
// (R2) any shutdown fault pulls the shutdown alert low
// (R3) warning output low while temperature is above warning level
// (R4) both outputs high only with no warning and no fault
// (R5) reset held low forces the shutdown alert high
// (R6) controller should lower volume when the warning appears
// (R7) a fault puts the power stage in Hi-Z and alerts at once
// (R8) faults other than overload and thermal error recover by themselves
// (R9) bootstrap undervoltage disables its half-bridge only, no latch, no alert
// (R10) over-current response is per-cycle limiting or latched shutdown
// (R11) overload shutdown holds the output Hi-Z until reset
// (R12) per-cycle limiting acts independently for each half-bridge
// (R13) over-current flips the half-bridge until next PWM frame start
// (R14) overload counter up per event, down per clean PWM cycle
// (R15) counter at maximum shuts down the affected channel
// (R16) latched mode shuts down on the first over-current event
// (R17) trip settings 0..3 select per-cycle mode, 17.0A to 12.9A
// (R18) trip settings 4..7 select latched mode, 17.0A to 12.9A
// (R19) trip setting outside both ranges applies minimum threshold
// (R20) thermal shutdown error latches until reset
// (R21) counter width and maximum are parameters, counter saturates
// (R22) channel shutdown disables the half-bridges of its channel group
`timescale 1ns/1ps
module amplifier_fault_protection #(
    parameter int OL_CNT_W = 3,
    parameter int OL_MAX   = 7
) (
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire amp_fault_pkg::sense_type      sense,
    input  wire logic                          pwm_frame_start,
    output amp_fault_pkg::bridge_ctrl_type     bridge,
    output logic                               per_cycle_current_limit,
    output logic      [1:0]                    trip_level,
    output logic                               shutdown_alert_out,
    output logic                               shutdown_alert_oe_n,
    output logic                               clip_heat_warn_n_out,
    output logic                               clip_heat_warn_n_oe_n
);
    import amp_fault_pkg::*;

    localparam logic [OL_CNT_W-1:0] CNT_MAX = OL_CNT_W'(OL_MAX);
    localparam logic [OL_CNT_W-1:0] CNT_ONE = OL_CNT_W'(1);

    // half-bridges grouped into the channel of the given one
    function automatic logic [3:0] group_mask(input out_cfg_type cfg, input int hb);
        logic [3:0] m;
        m = 4'h0;
        unique case (cfg)
            CFG_PBTL: m = 4'hF;
            CFG_SE:   m[hb] = 1'b1;
            default:  m = (hb < 2) ? 4'h3 : 4'hC;
        endcase
        return m;
    endfunction : group_mask

    // registers
    logic [31:0]          ctrl;
    sense_type            sense_meta;
    sense_type            sense_sync;
    logic [3:0]           oc_prev;
    logic [3:0]           oc_event;
    logic                 thermal_shutdown_error;
    logic [3:0]           hb_overload;
    logic [3:0]           oc_in_frame;
    logic [3:0]           flip;
    logic [OL_CNT_W-1:0]  ol_cnt [HB_COUNT];
    logic                 ph_valid;
    logic                 ph_write;
    logic [7:0]           ph_addr;

    logic [3:0]           trip_select;
    out_cfg_type          out_cfg;
    logic                 overload_fault;
    logic                 supply_low_protect;
    logic                 shutdown_fault;
    logic [3:0]           channel_off;

    assign trip_select = ctrl[TRIP_LSB +: TRIP_W];
    assign out_cfg     = out_cfg_type'(ctrl[CFG_LSB +: CFG_W]);

    // mode and threshold decode
    always_comb begin
        if (trip_select <= TRIP_PC_LAST) begin                 // see (R17)
            per_cycle_current_limit = 1'b1;
            trip_level = trip_select[1:0];
        end else if (trip_select <= TRIP_LAT_LAST) begin       // see (R18)
            per_cycle_current_limit = 1'b0;
            trip_level = trip_select[1:0];
        end else begin
            // out of range keeps limiting but at the lowest trip current
            per_cycle_current_limit = 1'b1;
            trip_level = LEVEL_12A9;                           // see (R19)
        end
    end

    // two-stage synchroniser; edge detect only reads the second stage
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sense_meta <= '0;
            sense_sync <= '0;
        end else begin
            sense_meta <= sense;
            sense_sync <= sense_meta;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            oc_prev <= 4'h0;
        end else begin
            oc_prev <= sense_sync.over_current;
        end
    end
    assign oc_event = sense_sync.over_current & ~oc_prev;

    // thermal error only clears through reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            thermal_shutdown_error <= 1'b0;
        end else if (sense_sync.temp_shutdown) begin
            thermal_shutdown_error <= 1'b1;                    // see (R20)
        end
    end

    // per half-bridge over-current handling
    generate
        for (genvar i = 0; i < HB_COUNT; i++) begin : g_hb
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    flip[i] <= 1'b0;
                end else if (oc_event[i] && per_cycle_current_limit) begin
                    flip[i] <= 1'b1;                           // see (R12) see (R13)
                end else if (pwm_frame_start) begin
                    flip[i] <= 1'b0;                           // see (R13)
                end
            end

            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    oc_in_frame[i] <= 1'b0;
                end else if (oc_event[i]) begin
                    oc_in_frame[i] <= 1'b1;
                end else if (pwm_frame_start) begin
                    oc_in_frame[i] <= 1'b0;
                end
            end

            // saturating overload counter
            always_ff @(posedge mclk) begin
                if (!reset_n || !per_cycle_current_limit) begin
                    ol_cnt[i] <= '0;
                end else if (oc_event[i]) begin
                    if (ol_cnt[i] != CNT_MAX) begin
                        ol_cnt[i] <= ol_cnt[i] + CNT_ONE;      // see (R14) see (R21)
                    end
                end else if (pwm_frame_start && !oc_in_frame[i]) begin
                    if (ol_cnt[i] != '0) begin
                        ol_cnt[i] <= ol_cnt[i] - CNT_ONE;      // see (R14) see (R21)
                    end
                end
            end

            // overload latch, released by reset only
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    hb_overload[i] <= 1'b0;
                end else if (per_cycle_current_limit && ol_cnt[i] == CNT_MAX) begin
                    hb_overload[i] <= 1'b1;                    // see (R15) see (R11)
                end else if (!per_cycle_current_limit && oc_event[i]) begin
                    hb_overload[i] <= 1'b1;                    // see (R16) see (R10)
                end
            end
        end
    endgenerate

    always_comb begin
        channel_off = 4'h0;
        for (int i = 0; i < HB_COUNT; i++) begin
            if (hb_overload[i]) begin
                channel_off = channel_off | group_mask(out_cfg, i);   // see (R22)
            end
        end
    end

    assign overload_fault     = |hb_overload;
    // supply fault follows the pin and clears by itself
    assign supply_low_protect = sense_sync.supply_low;               // see (R8)
    assign shutdown_fault     = thermal_shutdown_error | overload_fault | supply_low_protect;

    // bridge drive, registered
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bridge <= '0;
        end else begin
            bridge.hiz  <= channel_off
                         | {HB_COUNT{thermal_shutdown_error | supply_low_protect}};  // see (R7)
            bridge.flip <= flip;
            bridge.high_side_off <= sense_sync.bootstrap_supply_low;        // see (R9)
        end
    end

    // open-drain report pins: out is always 0, enable low pulls the wire
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            shutdown_alert_oe_n   <= 1'b1;                     // see (R5)
            clip_heat_warn_n_oe_n <= 1'b1;
        end else begin
            shutdown_alert_oe_n   <= ~shutdown_fault;          // see (R2) see (R4) see (R7)
            clip_heat_warn_n_oe_n <= ~sense_sync.temp_warn;    // see (R3) see (R4)
        end
    end
    assign shutdown_alert_out   = 1'b0;                        // see (R1)
    assign clip_heat_warn_n_out = 1'b0;                        // see (R1)

    // AHB-Lite slave, zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else if (hready) begin
            ph_valid <= hsel && htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl <= CTRL_RESET;
        end else if (ph_valid && ph_write && ph_addr == CTRL_OFFSET) begin
            ctrl <= {26'h0, hwdata[CFG_LSB +: CFG_W], hwdata[TRIP_LSB +: TRIP_W]};
        end
    end

    // read data registered in the address phase for the next data phase
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= 32'h0000_0000;
            unique case (haddr[7:0])
                CTRL_OFFSET: hrdata <= ctrl;
                STATUS_OFFSET: begin
                    hrdata[ST_ALERT_BIT]   <= ~shutdown_alert_oe_n;
                    hrdata[ST_WARN_BIT]    <= ~clip_heat_warn_n_oe_n;
                    hrdata[ST_THERMAL_BIT] <= thermal_shutdown_error;
                    hrdata[ST_SUPPLY_BIT]  <= supply_low_protect;
                    hrdata[ST_OVL_LSB +: HB_COUNT]  <= hb_overload;
                    hrdata[ST_FLIP_LSB +: HB_COUNT] <= flip;
                    hrdata[ST_BST_LSB +: HB_COUNT]  <= sense_sync.bootstrap_supply_low;
                    hrdata[ST_MODE_BIT]             <= per_cycle_current_limit;
                    hrdata[ST_LEVEL_LSB +: 2]       <= trip_level;
                end
                OLCNT_OFFSET: begin
                    for (int i = 0; i < HB_COUNT; i++) begin
                        hrdata[i*OLCNT_FIELD_W +: OL_CNT_W] <= ol_cnt[i];
                    end
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : amplifier_fault_protection

// file: tb/amp_fault_assertions.sv
`timescale 1ns/1ps
module amp_fault_checker (
    input wire logic                           mclk,
    input wire logic                           reset_n,
    input wire amp_fault_pkg::sense_type       sense,
    input wire logic                           pwm_frame_start,
    input wire amp_fault_pkg::bridge_ctrl_type bridge,
    input wire logic                           per_cycle_current_limit,
    input wire logic                           shutdown_alert_out,
    input wire logic                           shutdown_alert_oe_n,
    input wire logic                           clip_heat_warn_n_out,
    input wire logic                           clip_heat_warn_n_oe_n
);
    import amp_fault_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_pins_drive_low: assert property (
        !shutdown_alert_out && !clip_heat_warn_n_out)
        else $error("report pin data not low");
    a_reset_release: assert property (
        disable iff (1'b0) !reset_n |=> shutdown_alert_oe_n)
        else $error("alert pulled during reset");
    // sync chain plus output flop gives three cycles
    a_warn_tracks_temp: assert property (
        reset_n[*5] |-> clip_heat_warn_n_oe_n == !$past(sense.temp_warn, 3))
        else $error("warning not following temperature");
    a_bst_high_side: assert property (
        reset_n[*5] |-> bridge.high_side_off == $past(sense.bootstrap_supply_low, 3))
        else $error("high side off not following bootstrap");
    a_supply_low_trip: assert property (
        $rose(sense.supply_low) |-> ##[2:4] (!shutdown_alert_oe_n && bridge.hiz == 4'hF))
        else $error("supply low did not trip");
    a_normal_no_hiz: assert property (
        shutdown_alert_oe_n && clip_heat_warn_n_oe_n |-> bridge.hiz == 4'h0)
        else $error("hiz while reporting normal");
    a_flip_clear_frame: assert property (
        |($past(bridge.flip) & ~bridge.flip) |-> $past(pwm_frame_start, 2))
        else $error("flip cleared off frame start");
    a_latched_first_oc: assert property (
        !per_cycle_current_limit && $rose(sense.over_current[3]) |-> ##[2:4] bridge.hiz[3])
        else $error("latched mode missed first event");
    cover property ($fell(bridge.flip[1]));
    cover property ($fell(shutdown_alert_oe_n));
    cover property ($fell(clip_heat_warn_n_oe_n));
endmodule : amp_fault_checker

bind amplifier_fault_protection amp_fault_checker u_chk (
    .mclk(mclk), .reset_n(reset_n), .sense(sense), .pwm_frame_start(pwm_frame_start),
    .bridge(bridge), .per_cycle_current_limit(per_cycle_current_limit),
    .shutdown_alert_out(shutdown_alert_out), .shutdown_alert_oe_n(shutdown_alert_oe_n),
    .clip_heat_warn_n_out(clip_heat_warn_n_out), .clip_heat_warn_n_oe_n(clip_heat_warn_n_oe_n)
);

// file: tb/amp_host_monitor.sv
`timescale 1ns/1ps
module amp_host_monitor (
    input  wire logic alert_oe_n,
    input  wire logic alert_out,
    input  wire logic warn_oe_n,
    input  wire logic warn_out,
    output logic      fault_pin,
    output logic      warn_pin,
    output logic      volume_down
);
    // pull-up holds a released pin high
    assign fault_pin   = alert_oe_n ? 1'b1 : alert_out;
    assign warn_pin    = warn_oe_n ? 1'b1 : warn_out;
    // back off before heat forces a shutdown
    assign volume_down = !warn_pin;
endmodule : amp_host_monitor

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import amp_fault_pkg::*;
    logic            mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, pwm_frame_start = 0;
    logic [31:0]     haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]      htrans = 0, trip_level;
    logic            hreadyout, hresp, per_cycle_current_limit;
    sense_type       sense = '0;
    bridge_ctrl_type bridge;
    logic            sa_out, sa_oe_n, cw_out, cw_oe_n, fault_pin, warn_pin, volume_down;
    int              n_mismatch = 0, checked = 0;
    always #2 mclk = ~mclk;
    amplifier_fault_protection #(.OL_CNT_W(3), .OL_MAX(3)) u_dut (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sense(sense), .pwm_frame_start(pwm_frame_start),
        .bridge(bridge), .per_cycle_current_limit(per_cycle_current_limit),
        .trip_level(trip_level), .shutdown_alert_out(sa_out), .shutdown_alert_oe_n(sa_oe_n),
        .clip_heat_warn_n_out(cw_out), .clip_heat_warn_n_oe_n(cw_oe_n));
    amp_host_monitor u_host (.alert_oe_n(sa_oe_n), .alert_out(sa_out), .warn_oe_n(cw_oe_n),
        .warn_out(cw_out), .fault_pin(fault_pin), .warn_pin(warn_pin),
        .volume_down(volume_down));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wait_ready();
        int k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_ready
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic rst();
        reset_n <= 0;
        cyc(2);
        chk("fault in reset", 1, fault_pin);
        reset_n <= 1;
        cyc(5);
    endtask : rst
    task automatic frame();
        pwm_frame_start <= 1;
        cyc(1);
        pwm_frame_start <= 0;
        cyc(2);
    endtask : frame
    task automatic oc(int i);
        sense.over_current[i] <= 1;
        cyc(3);
        sense.over_current[i] <= 0;
        cyc(4);
    endtask : oc
    task automatic t_idle();
        chk("idle pins", 2'b11, {fault_pin, warn_pin});
        chk("hresp", 0, hresp);
        bus(0, CTRL_OFFSET, 0);
        chk("ctrl reset", CTRL_RESET, rd);
        bus(0, 8'h40, 0);
        chk("unmapped", 0, rd);
        $display("idle done");
    endtask : t_idle
    task automatic t_warn();
        sense.temp_warn <= 1;
        cyc(5);
        chk("warn pins", 2'b10, {fault_pin, warn_pin});
        chk("volume", 1, volume_down);
        sense.temp_warn <= 0;
        cyc(5);
        chk("warn clear", 1, warn_pin);
        chk("volume off", 0, volume_down);
        $display("warn done");
    endtask : t_warn
    task automatic t_supply();
        sense.supply_low <= 1;
        cyc(5);
        chk("supply fault", 0, fault_pin);
        chk("supply hiz", 4'hF, bridge.hiz);
        bus(0, STATUS_OFFSET, 0);
        chk("status supply", 32'h0001_0009, rd);
        sense.supply_low <= 0;
        cyc(5);
        chk("supply back", {1'b1, 4'h0}, {fault_pin, bridge.hiz});
        $display("supply done");
    endtask : t_supply
    task automatic t_bst();
        sense.bootstrap_supply_low <= 4'h4;
        cyc(5);
        chk("bst no fault", {1'b1, 4'h0}, {fault_pin, bridge.hiz});
        chk("bst off", 4'h4, bridge.high_side_off);
        sense.bootstrap_supply_low <= 4'h0;
        cyc(5);
        chk("bst back", 0, bridge.high_side_off);
        $display("bootstrap done");
    endtask : t_bst
    task automatic t_trip();
        for (int i = 0; i < 16; i++) begin
            bus(1, CTRL_OFFSET, 32'(i));
            cyc(1);
            chk("mode", (i < 4 || i > 7), per_cycle_current_limit);
            chk("level", i > 7 ? LEVEL_12A9 : 2'(i % 4), trip_level);
        end
        $display("trip done");
    endtask : t_trip
    task automatic t_cycle();
        rst();
        oc(1);
        chk("flip", 4'h2, bridge.flip);
        bus(0, OLCNT_OFFSET, 0);
        chk("count up", 1, rd[10:8]);
        frame();
        chk("flip cleared", 0, bridge.flip);
        bus(0, OLCNT_OFFSET, 0);
        chk("count held", 1, rd[10:8]);
        frame();
        bus(0, OLCNT_OFFSET, 0);
        chk("count down", 0, rd[10:8]);
        repeat (3) oc(1);
        cyc(2);
        chk("overload", {1'b0, 4'h3}, {fault_pin, bridge.hiz});
        frame();
        cyc(3);
        chk("overload held", 4'h3, bridge.hiz);
        rst();
        chk("overload cleared", 4'h0, bridge.hiz);
        $display("per cycle done");
    endtask : t_cycle
    task automatic t_latched();
        bus(1, CTRL_OFFSET, 32'h24);
        oc(2);
        chk("single ended", {1'b0, 4'h4}, {fault_pin, bridge.hiz});
        rst();
        bus(1, CTRL_OFFSET, 32'h14);
        oc(3);
        chk("latched", {1'b0, 4'hF}, {fault_pin, bridge.hiz});
        chk("latched no flip", 4'h0, bridge.flip);
        rst();
        chk("latched cleared", 4'h0, bridge.hiz);
        $display("latched done");
    endtask : t_latched
    task automatic t_thermal();
        sense.temp_shutdown <= 1;
        cyc(5);
        sense.temp_shutdown <= 0;
        cyc(5);
        chk("thermal held", {1'b0, 4'hF}, {fault_pin, bridge.hiz});
        rst();
        chk("thermal cleared", 1, fault_pin);
        $display("thermal done");
    endtask : t_thermal
    initial begin
        cyc(12);
        reset_n <= 1;
        cyc(5);
        t_idle();
        t_warn();
        t_supply();
        t_bst();
        t_trip();
        t_cycle();
        t_latched();
        t_thermal();
        give_verdict();
    end
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : testbench
